// >>> design/cbt_pkg.sv
// package for the can bit timing and synchronisation block
// assumes one oscillator clock and an 8-bit register port
package cbt_pkg;

    // register offsets
    localparam logic [7:0] CFG3_ADDR = 8'h28;
    localparam logic [7:0] CFG2_ADDR = 8'h29;
    localparam logic [7:0] CFG1_ADDR = 8'h2A;
    localparam logic [7:0] STAT_ADDR = 8'h2B;

    // cfg1 fields
    localparam int SJW_POS = 6;
    localparam int BRP_POS = 0;
    // cfg2 fields
    localparam int BTL_POS = 7;
    localparam int SAM_POS = 6;
    localparam int PH1_POS = 3;
    localparam int PROP_POS = 0;
    // cfg3 field
    localparam int PH2_POS = 0;
    // status fields
    localparam int ST_BIT_POS = 7;
    localparam int ST_SYNC_POS = 6;
    localparam int ST_SEG_POS = 4;

    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG3_RST = 8'h00;

    // timing counts in quanta
    localparam logic [4:0] IPT_TQ = 5'h02;
    localparam logic [4:0] PH2_MIN_TQ = 5'h02;

    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_PROP = 2'b01,
        SEG_PH1 = 2'b10,
        SEG_PH2 = 2'b11
    } cbt_seg_e;

    typedef struct packed {
        logic [1:0] sjw;
        logic [5:0] quantum_prescaler;
        logic phase_two_length_select;
        logic triple_sample_select;
        logic [2:0] phase_one_length_field;
        logic [2:0] propagation_length_field;
        logic [2:0] phase_two_length_field;
    } cbt_cfg_s;

endpackage : cbt_pkg

// >>> design/cbt_tq_prescaler.sv
// quantum-rate enable generator
// assumes the prescaler field is held steady while the bus runs
`timescale 1ns/1ps
module cbt_tq_prescaler
    import cbt_pkg::*;
#(
    parameter int PW = 6
)
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [PW-1:0] quantum_prescaler_i,
    output logic tq_tick_o,
    output logic half_tick_o
);

    logic [PW:0] cnt;
    logic [PW:0] last;

    // quantum is 2*(field+1) oscillator periods
    assign last = {quantum_prescaler_i, 1'b1};
    assign tq_tick_o = (cnt == last);
    assign half_tick_o = (cnt == {1'b0, quantum_prescaler_i});

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            cnt <= '0;
        else if (cnt >= last)
            cnt <= '0;
        else
            cnt <= cnt + 1'b1;
    end

endmodule : cbt_tq_prescaler

// >>> design/cbt_rx_vote.sv
// receive pin synchroniser and three-sample majority vote
// assumes half and full quantum ticks from the prescaler
`timescale 1ns/1ps
module cbt_rx_vote
    import cbt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic can_rx_i,
    input wire logic half_tick_i,
    input wire logic tq_tick_i,
    input wire logic triple_i,
    output logic rx_now_o,
    output logic vote_o
);

    logic rx_meta;
    logic rx_sync;
    logic [1:0] hist;

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= can_rx_i;
            rx_sync <= rx_meta;
        end
    end

    // history holds the level one quantum and half a quantum back
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            hist <= 2'b11;
        else if (half_tick_i || tq_tick_i)
            hist <= {hist[0], rx_sync};
    end

    assign rx_now_o = rx_sync;
    assign vote_o = triple_i ? ((hist[1] & hist[0]) | (hist[1] & rx_sync) | (hist[0] & rx_sync))
                             : rx_sync;

endmodule : cbt_rx_vote

// >>> design/cbt_bit_timing.sv
// can bit timing and synchronisation: segment sequencer and registers
// assumes bus idle and transmitting flags from the protocol engine
// on the same clock, and a plain 8-bit register port
//
// Behaviour
// - bit time is sync, propagation, phase one and phase two in sequence
// - sync segment opens each bit and lasts one quantum
// - propagation segment programmable from one to eight quanta
// - phase one 1..8 quanta, phase two 2..8 quanta
// - single mode samples the bus once at the end of phase one
// - triple mode adds two half-quantum-spaced samples and takes the majority
// - bit processing takes two quanta from the sample point
// - phase two never shorter than the processing time; a shortening by the jump width can leave it at one quantum
// - jump width programmable from one to four quanta
// - quantum is two oscillator periods times the prescaler
// - hard sync on falling edge while idle restarts the bit
// - no resync after a hard sync in the same bit
// - phase error zero in sync, positive before, negative after sample
// - small phase error acts like a hard sync
// - large positive error lengthens phase one by the jump width
// - large negative error shortens phase two by the jump width
// - only recessive-to-dominant edges synchronise
// - at most one synchronisation per bit time
// - edge counts only if previous sampled bit differs from new level
// - transmitter ignores edges with positive phase error
// - stuffing keeps an edge at least every six bits
// - prescaler field sets quantum as two times (field plus one) oscillator periods
// - jump width field plus one gives its length
// - phase two from its own field or the larger of phase one and two
`timescale 1ns/1ps
module cbt_bit_timing
    import cbt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic can_rx_i,
    output logic can_tx_o,
    input wire logic tx_bit_i,
    input wire logic bus_idle_i,
    input wire logic transmitting_i,
    output logic rx_bit_o,
    output logic sample_point_o,
    output logic bit_valid_o,
    output logic bit_start_o
);

    cbt_cfg_s cfg;
    cbt_seg_e seg;
    logic [4:0] cnt;
    logic [4:0] pos;
    logic [4:0] ph1_ext;
    logic [4:0] ph2_red;
    logic sync_done;
    logic edge_pend;
    logic rx_prev;
    logic [4:0] ipt_cnt;

    logic tq_tick;
    logic half_tick;
    logic rx_now;
    logic vote;

    logic [4:0] prop_len;
    logic [4:0] ph1_len;
    logic [4:0] ph2_len;
    logic [4:0] sjw_len;
    logic [4:0] ph1_end;
    logic [4:0] ph2_end;
    logic [4:0] err_mag;
    logic edge_evt;
    logic edge_hit;
    logic err_pos;
    logic restart;
    logic lengthen;
    logic shorten;
    logic [4:0] cnt_inc;

    function automatic logic [4:0] max5(input logic [4:0] a, input logic [4:0] b);
        max5 = (a > b) ? a : b;
    endfunction : max5

    cbt_tq_prescaler #(
        .PW(6)
    ) u_presc (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .quantum_prescaler_i(cfg.quantum_prescaler),
        .tq_tick_o(tq_tick),
        .half_tick_o(half_tick)
    );

    cbt_rx_vote u_vote (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .can_rx_i(can_rx_i),
        .half_tick_i(half_tick),
        .tq_tick_i(tq_tick),
        .triple_i(cfg.triple_sample_select),
        .rx_now_o(rx_now),
        .vote_o(vote)
    );

    // segment lengths in quanta
    assign prop_len = {2'b00, cfg.propagation_length_field} + 5'h01;
    assign ph1_len = {2'b00, cfg.phase_one_length_field} + 5'h01;
    assign sjw_len = {3'b000, cfg.sjw} + 5'h01;
    // phase two clamped to the processing time even if the field says one
    assign ph2_len = cfg.phase_two_length_select
        ? max5({2'b00, cfg.phase_two_length_field} + 5'h01, PH2_MIN_TQ)
        : max5(ph1_len, IPT_TQ);

    // falling edge of the synchronised line; rising edges never count
    assign edge_evt = rx_prev && !rx_now;
    // previous sample recessive, new level dominant, one sync per bit
    assign edge_hit = (edge_evt || edge_pend) && rx_bit_o && !sync_done;

    // phase error of the edge, measured in the quantum it fell into
    assign err_pos = (seg == SEG_PROP) || (seg == SEG_PH1);
    assign err_mag = err_pos ? pos : ((seg == SEG_PH2) ? (ph2_len - cnt) : 5'h00);

    always_comb
    begin
        restart = 1'b0;
        lengthen = 1'b0;
        shorten = 1'b0;
        if (edge_hit)
        begin
            if (bus_idle_i)
                restart = 1'b1;
            else if (!(err_pos && transmitting_i))
            begin
                if (err_mag <= sjw_len)
                    restart = 1'b1;
                else if (err_pos)
                    lengthen = 1'b1;
                else
                    shorten = 1'b1;
            end
        end
    end

    assign cnt_inc = cnt + 5'h01;
    assign ph1_end = ph1_len + (lengthen ? sjw_len : ph1_ext);
    // guard against a jump width not below phase two
    assign ph2_end = (ph2_len > (shorten ? sjw_len : ph2_red))
        ? ph2_len - (shorten ? sjw_len : ph2_red) : 5'h01;

    // edges between quantum ticks wait for the next tick
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            rx_prev <= 1'b1;
        else
            rx_prev <= rx_now;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            edge_pend <= 1'b0;
        else if (tq_tick)
            edge_pend <= 1'b0;
        else if (edge_evt)
            edge_pend <= 1'b1;
    end

    // segment sequencer, one step per quantum
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            seg <= SEG_SYNC;
            cnt <= 5'h00;
            pos <= 5'h00;
        end
        else if (tq_tick)
        begin
            if (restart)
            begin
                // the edge quantum becomes the sync segment
                seg <= SEG_PROP;
                cnt <= 5'h00;
                pos <= 5'h01;
            end
            else
            begin
                case (seg)
                    SEG_SYNC:
                    begin
                        seg <= SEG_PROP;
                        cnt <= 5'h00;
                        pos <= 5'h01;
                    end
                    SEG_PROP:
                    begin
                        pos <= pos + 5'h01;
                        if (cnt_inc >= prop_len)
                        begin
                            seg <= SEG_PH1;
                            cnt <= 5'h00;
                        end
                        else
                            cnt <= cnt_inc;
                    end
                    SEG_PH1:
                    begin
                        pos <= pos + 5'h01;
                        if (cnt_inc >= ph1_end)
                        begin
                            seg <= SEG_PH2;
                            cnt <= 5'h00;
                        end
                        else
                            cnt <= cnt_inc;
                    end
                    SEG_PH2:
                    begin
                        if (cnt_inc >= ph2_end)
                        begin
                            seg <= SEG_SYNC;
                            cnt <= 5'h00;
                            pos <= 5'h00;
                        end
                        else
                            cnt <= cnt_inc;
                    end
                    default:
                    begin
                        seg <= SEG_SYNC;
                        cnt <= 5'h00;
                        pos <= 5'h00;
                    end
                endcase
            end
        end
    end

    // phase adjustments last until the next bit starts
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            ph1_ext <= 5'h00;
            ph2_red <= 5'h00;
        end
        else if (tq_tick)
        begin
            if (restart || (seg == SEG_SYNC))
            begin
                ph1_ext <= 5'h00;
                ph2_red <= 5'h00;
            end
            else if (lengthen)
                ph1_ext <= sjw_len;
            else if (shorten)
                ph2_red <= sjw_len;
        end
    end

    // one synchronisation per bit; cleared as the next sync segment opens
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            sync_done <= 1'b0;
        else if (tq_tick)
        begin
            // a shortening that ends phase two opens a fresh bit, so the clear wins
            if (restart)
                sync_done <= 1'b1;
            else if ((seg == SEG_PH2) && (cnt_inc >= ph2_end))
                sync_done <= 1'b0;
            else if (lengthen || shorten)
                sync_done <= 1'b1;
        end
    end

    // sample point at the end of phase one
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            rx_bit_o <= 1'b1;
            sample_point_o <= 1'b0;
        end
        else
        begin
            sample_point_o <= 1'b0;
            if (tq_tick && !restart && (seg == SEG_PH1) && (cnt_inc >= ph1_end))
            begin
                rx_bit_o <= vote;
                sample_point_o <= 1'b1;
            end
        end
    end

    // bit handed on once the processing time has run out
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            ipt_cnt <= 5'h00;
            bit_valid_o <= 1'b0;
        end
        else
        begin
            bit_valid_o <= 1'b0;
            if (sample_point_o)
                ipt_cnt <= IPT_TQ;
            else if (tq_tick && (ipt_cnt != 5'h00))
            begin
                ipt_cnt <= ipt_cnt - 5'h01;
                if (ipt_cnt == 5'h01)
                    bit_valid_o <= 1'b1;
            end
        end
    end

    // transmit level changes only as a new bit opens
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            can_tx_o <= 1'b1;
            bit_start_o <= 1'b0;
        end
        else
        begin
            bit_start_o <= 1'b0;
            if (tq_tick && !restart && (seg == SEG_PH2) && (cnt_inc >= ph2_end))
            begin
                can_tx_o <= tx_bit_i;
                bit_start_o <= 1'b1;
            end
        end
    end

    // configuration registers; software must meet the segment inequalities
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            cfg <= {CFG1_RST, CFG2_RST, CFG3_RST[2:0]};
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                CFG1_ADDR:
                begin
                    cfg.sjw <= reg_wdata_i[SJW_POS +: 2];
                    cfg.quantum_prescaler <= reg_wdata_i[BRP_POS +: 6];
                end
                CFG2_ADDR:
                begin
                    cfg.phase_two_length_select <= reg_wdata_i[BTL_POS];
                    cfg.triple_sample_select <= reg_wdata_i[SAM_POS];
                    cfg.phase_one_length_field <= reg_wdata_i[PH1_POS +: 3];
                    cfg.propagation_length_field <= reg_wdata_i[PROP_POS +: 3];
                end
                CFG3_ADDR:
                    cfg.phase_two_length_field <= reg_wdata_i[PH2_POS +: 3];
                default:
                    cfg <= cfg;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                CFG1_ADDR:
                    reg_rdata_o <= {cfg.sjw, cfg.quantum_prescaler};
                CFG2_ADDR:
                    reg_rdata_o <= {cfg.phase_two_length_select, cfg.triple_sample_select,
                                    cfg.phase_one_length_field, cfg.propagation_length_field};
                CFG3_ADDR:
                    reg_rdata_o <= {5'h00, cfg.phase_two_length_field};
                STAT_ADDR:
                    reg_rdata_o <= {rx_bit_o, sync_done, seg, 4'h0};
                default:
                    reg_rdata_o <= 8'h00;
            endcase
        end
        else
            reg_rdata_o <= 8'h00;
    end

endmodule : cbt_bit_timing

// >>> testbench/cbt_bit_timing_monitor.sv
// concurrent checks on the ports of the bit timing block
// assumes one clock, synchronous active-low reset, bound at the foot
`timescale 1ns/1ps
module cbt_bit_timing_monitor
    import cbt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic can_rx_i,
    input wire logic can_tx_o,
    input wire logic tx_bit_i,
    input wire logic bus_idle_i,
    input wire logic transmitting_i,
    input wire logic rx_bit_o,
    input wire logic sample_point_o,
    input wire logic bit_valid_o,
    input wire logic bit_start_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    logic [7:0] sh1;
    logic wr_seen;
    logic [11:0] since_sp;
    logic [8:0] twoq;

    // prescaler shadow; a change mid-bit makes the quantum length unknown
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            sh1 <= CFG1_RST;
        else if (reg_wr_i && reg_addr_i == CFG1_ADDR)
            sh1 <= reg_wdata_i;
    end
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i || sample_point_o)
            wr_seen <= 1'b0;
        else if (reg_wr_i && reg_addr_i == CFG1_ADDR)
            wr_seen <= 1'b1;
    end
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i || sample_point_o)
            since_sp <= 12'h000;
        else if (since_sp != 12'hFFF)
            since_sp <= since_sp + 12'h001;
    end
    assign twoq = {1'b0, sh1[5:0], 2'b00} + 9'h004;

    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_rd_cfg1: assert property (reg_rd_i && reg_addr_i == CFG1_ADDR |=> reg_rdata_o == sh1)
        else $error("cfg1 read back differs from written value");
    a_rd_cfg3_pad: assert property (reg_rd_i && reg_addr_i == CFG3_ADDR
        |=> reg_rdata_o[7:3] == 5'h00)
        else $error("cfg3 upper bits not zero");
    a_rd_unmapped: assert property (reg_rd_i && (reg_addr_i < CFG3_ADDR || reg_addr_i > STAT_ADDR)
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_sample_once: assert property (sample_point_o |=> !sample_point_o [*3])
        else $error("sample points too close");
    a_valid_delay: assert property (bit_valid_o && !wr_seen
        |-> since_sp == {3'b000, twoq} - 12'h001)
        else $error("bit valid not two quanta after sample");
    a_rx_at_sample: assert property (!sample_point_o |-> $stable(rx_bit_o))
        else $error("received bit changed outside sample point");
    a_tx_hold: assert property (!bit_start_o |-> $stable(can_tx_o))
        else $error("transmit pin changed inside a bit");
    a_tx_value: assert property (bit_start_o |-> can_tx_o == $past(tx_bit_i))
        else $error("transmit pin not the requested bit");
    a_start_gap: assert property (bit_start_o |=> !bit_start_o [*4])
        else $error("bit starts too close");

    cover property (sample_point_o);
    cover property (bit_valid_o && !wr_seen);
    cover property (bit_start_o && !can_tx_o);
endmodule : cbt_bit_timing_monitor

bind cbt_bit_timing cbt_bit_timing_monitor u_mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .can_rx_i(can_rx_i), .can_tx_o(can_tx_o),
    .tx_bit_i(tx_bit_i), .bus_idle_i(bus_idle_i), .transmitting_i(transmitting_i),
    .rx_bit_o(rx_bit_o), .sample_point_o(sample_point_o), .bit_valid_o(bit_valid_o),
    .bit_start_o(bit_start_o));

// >>> testbench/cbt_bus_node.sv
// far-side node: pulls the bus dominant once per arm, at an offset
// from the next sample point; assumes recessive high, wired-and bus
`timescale 1ns/1ps
module cbt_bus_node
    import cbt_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arm_i,
    input wire logic sample_i,
    input wire logic [7:0] off_i,
    input wire logic [7:0] len_i,
    input wire logic tx_i,
    output logic rx_o
);
    logic pending = 1'b0;
    logic busy = 1'b0;
    logic drive_n = 1'b1;
    logic [7:0] cnt = 8'h00;

    always @(posedge mclk_i)
    begin
        if (arm_i)
            pending <= 1'b1;
        else if (pending && sample_i)
        begin
            pending <= 1'b0;
            busy <= 1'b1;
            cnt <= 8'h00;
        end
        else if (busy)
        begin
            cnt <= cnt + 8'h01;
            if (cnt == off_i)
                drive_n <= 1'b0;
            if (cnt == off_i + len_i)
            begin
                drive_n <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
    // dominant from either party wins
    assign rx_o = drive_n & tx_i;
endmodule : cbt_bus_node

// >>> testbench/cbt_bit_timing_tb_top.sv
// self-checking bench: register access, bit lengths, synchronisation
// assumes the bus node model as the only other party on the wire
`timescale 1ns/1ps
module cbt_bit_timing_tb_top
    import cbt_pkg::*;
;
    logic mclk, rst_n, wr, rd, rx, tx_bit, idle, xmit, arm;
    logic [7:0] addr, wdata, rdata, off, len, d, c1, c2, c3, off_v, fl, ex;
    logic can_tx, rx_bit, sp, bv, bs;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int i, t1, t2, t3, spo, exp_len;
    logic [23:0] lrow [4] = '{24'h000000, 24'h3FBF07, 24'h011807, 24'h008202};
    // offset, flags {idle, transmitting, triple}, expected sample spacing
    logic [23:0] srow [8] = '{24'h290058, 24'h410060, 24'h190048, 24'h090040,
        24'h210050, 24'h410250, 24'h410470, 24'h290158};

    cbt_bit_timing u_dut (.mclk_i(mclk), .resetn_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .can_rx_i(rx), .can_tx_o(can_tx), .tx_bit_i(tx_bit), .bus_idle_i(idle),
        .transmitting_i(xmit), .rx_bit_o(rx_bit), .sample_point_o(sp),
        .bit_valid_o(bv), .bit_start_o(bs));
    cbt_bus_node u_node (.mclk_i(mclk), .arm_i(arm), .sample_i(sp), .off_i(off),
        .len_i(len), .tx_i(can_tx), .rx_o(rx));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task end_of_test;
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task chk_n(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_n

    task reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr

    task rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk8(rdata & m, e);
    endtask : rd_chk

    // sel 0 waits for a sample point, 1 for a bit start
    task wait_p(input int sel, output int t);
        int n;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while ((sel == 0 ? sp : bs) !== 1'b1 && n < 4000);
        t = cyc;
    endtask : wait_p

    function automatic int blen(input logic [7:0] a, input logic [7:0] b,
                                input logic [7:0] c, output int sp_off);
        int q;
        int ph1;
        int ph2;
        q = 2 * (int'(a[5:0]) + 1);
        ph1 = int'(b[5:3]) + 1;
        ph2 = b[7] ? int'(c[2:0]) + 1 : ph1;
        if (ph2 < 2)
            ph2 = 2;
        sp_off = q * (2 + int'(b[2:0]) + ph1);
        return q * (2 + int'(b[2:0]) + ph1 + ph2);
    endfunction : blen

    initial
    begin
        {rst_n, wr, rd, idle, xmit, arm} = 6'h00;
        tx_bit = 1'b1;
        {addr, wdata, off} = 24'h000000;
        len = 8'h3C;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(CFG1_ADDR, 8'hFF, CFG1_RST);
        rd_chk(CFG2_ADDR, 8'hFF, CFG2_RST);
        rd_chk(CFG3_ADDR, 8'hFF, CFG3_RST);
        reg_wr(CFG1_ADDR, 8'hA5);
        reg_wr(CFG2_ADDR, 8'h5A);
        reg_wr(CFG3_ADDR, 8'hFF);
        reg_wr(8'h27, 8'hFF);
        reg_wr(STAT_ADDR, 8'hFF);
        rd_chk(CFG1_ADDR, 8'hFF, 8'hA5);
        rd_chk(CFG2_ADDR, 8'hFF, 8'h5A);
        rd_chk(CFG3_ADDR, 8'hFF, 8'h07);
        rd_chk(8'h27, 8'hFF, 8'h00);
        rd_chk(STAT_ADDR, 8'h0F, 8'h00);
        // settings kept to the segment inequalities of the far side
        for (i = 0; i < 4; i++)
        begin
            {c1, c2, c3} = lrow[i];
            reg_wr(CFG1_ADDR, c1);
            reg_wr(CFG2_ADDR, c2);
            reg_wr(CFG3_ADDR, c3);
            tx_bit <= (i != 1);
            repeat (3) wait_p(1, t1);
            wait_p(0, t2);
            wait_p(1, t3);
            exp_len = blen(c1, c2, c3, spo);
            chk_n(t3 - t1, exp_len);
            chk_n(t2 - t1, spo);
        end
        tx_bit <= 1'b1;
        // quantum 8 clocks, jump width 2, bit 1+1+4+4 quanta
        for (i = 0; i < 8; i++)
        begin
            {off_v, fl, ex} = srow[i];
            reg_wr(CFG1_ADDR, 8'h43);
            reg_wr(CFG2_ADDR, fl[0] ? 8'hD8 : 8'h98);
            reg_wr(CFG3_ADDR, 8'h03);
            idle <= fl[2];
            xmit <= fl[1];
            off <= off_v;
            repeat (3) wait_p(0, t1);
            @(posedge mclk);
            arm <= 1'b1;
            @(posedge mclk);
            arm <= 1'b0;
            wait_p(0, t1);
            wait_p(0, t2);
            chk_n(t2 - t1, int'(ex));
            chk8({7'h00, rx_bit}, 8'h00);
            wait_p(0, t3);
            chk_n(t3 - t2, 80);
        end
        end_of_test();
    end
endmodule : cbt_bit_timing_tb_top
